/* src/rscs_pkg.sv */
// shared constants and types for the reset cause status block
package rscs_pkg;
  // register data width
  localparam int unsigned RSCS_DW = 8;
  // watchdog service keys and the fixed read value of the force register
  localparam logic [RSCS_DW-1:0] RSCS_KEY_ARM   = 8'h55;
  localparam logic [RSCS_DW-1:0] RSCS_KEY_FIRE  = 8'hAA;
  localparam logic [RSCS_DW-1:0] RSCS_READ_ZERO = 8'h00;
  localparam logic [RSCS_DW-1:0] RSCS_ALL_CLEAR = 8'h00;
  // status field positions
  localparam int unsigned RSCS_BIT_POR  = 7;
  localparam int unsigned RSCS_BIT_PIN  = 6;
  localparam int unsigned RSCS_BIT_WDOG = 5;
  localparam int unsigned RSCS_BIT_ILLEGAL_OPCODE_FLAG = 4;
  localparam int unsigned RSCS_BIT_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int unsigned RSCS_BIT_RSV2 = 2;
  localparam int unsigned RSCS_BIT_LVD  = 1;
  localparam int unsigned RSCS_BIT_RSV0 = 0;
  // force_reset_bit position in debug_forced_reset
  localparam int unsigned RSCS_BIT_FORCE = 0;
  // register select codes on the register port
  localparam logic RSCS_SEL_STATUS = 1'b0;
  localparam logic RSCS_SEL_FORCE  = 1'b1;
  // watchdog key sequencer states
  typedef enum logic {
    RSCS_SEQ_IDLE  = 1'b0,
    RSCS_SEQ_ARMED = 1'b1
  } rscs_seq_e;
  // internal reset sources frozen at reset entry
  typedef struct packed {
    logic forced;
    logic low_voltage_reset;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
  } rscs_cause_s;
  localparam rscs_cause_s RSCS_CAUSE_NONE = '0;
endpackage

/* src/rscs_wdog_if.sv */
// link between the status register and the watchdog key sequencer
`timescale 1ns/1ns
interface rscs_wdog_if;
  import rscs_pkg::*;
  logic               wrStb;
  logic [RSCS_DW-1:0] wrData;
  logic               serviced;
  logic               badWrite;
  modport owner (output wrStb, output wrData,
                 input serviced, input badWrite);
  modport seqr  (input wrStb, input wrData,
                 output serviced, output badWrite);
endinterface

/* src/rscs_wdog_seq.sv */
// watchdog key sequencer for writes to the status address
`timescale 1ns/1ns
module rscs_wdog_seq
  import rscs_pkg::*;
(
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  // status address writes in, service and fault out
  rscs_wdog_if.seqr   wd
);

  rscs_seq_e stateQ_q;
  rscs_seq_e stateQ_d;

  // any key other than the two restarts the sequence; a lone fire key
  // neither services nor faults
  always_comb begin
    stateQ_d    = stateQ_q;
    wd.serviced = 1'b0;
    wd.badWrite = 1'b0;
    if (wd.wrStb) begin
      if (wd.wrData == RSCS_KEY_ARM) begin
        stateQ_d = RSCS_SEQ_ARMED;
      end else if (wd.wrData == RSCS_KEY_FIRE) begin
        wd.serviced = (stateQ_q == RSCS_SEQ_ARMED);
        stateQ_d    = RSCS_SEQ_IDLE;
      end else begin
        wd.badWrite = 1'b1;
        stateQ_d    = RSCS_SEQ_IDLE;
      end
    end
  end

  // sequencer state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ_q <= RSCS_SEQ_IDLE;
    end else begin
      stateQ_q <= stateQ_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_arm;
    wd.wrStb && wd.wrData == RSCS_KEY_ARM;
  endsequence
  sequence s_fire;
    wd.wrStb && wd.wrData == RSCS_KEY_FIRE;
  endsequence

  a_key_pair_services: assert property (
    s_arm ##1 s_fire |-> wd.serviced)
    else $error("key pair did not service the watchdog");

  a_bad_key_faults: assert property (
    wd.wrStb && wd.wrData != RSCS_KEY_ARM && wd.wrData != RSCS_KEY_FIRE
    |-> wd.badWrite && !wd.serviced)
    else $error("illegal key not flagged");

endmodule

/* src/rscs_top.sv */
// reset cause status register with debug forced reset
//
// Contract
// - status flags record the last reset cause
// - debug forced reset leaves all flags clear
// - enabled watchdog: other key values cause reset
// - key pair restarts watchdog, status unchanged
// - power-on sets bits 7 and 1 only
// - low-voltage sets bit 1, keeps bit 7
// - other resets: bits 6..3 follow active sources
// - bit 6 marks external pin reset
// - bit 5 marks watchdog; disabled means none
// - bit 4 marks illegal opcode, gated instructions
// - bit 3 marks illegal address access
// - processor writes to force register ignored
// - force register always reads zero
// - debug write of force bit resets device
// - low supply resets only when enabled
`timescale 1ns/1ns
module rscs_top
  import rscs_pkg::*;
(
  // clock and reset (rst_n is asserted by every reset source)
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // processor register port
  input  wire logic               cpuSel,
  input  wire logic               cpuWrEn,
  input  wire logic               cpuRdEn,
  input  wire logic [RSCS_DW-1:0] cpuWrData,
  output logic      [RSCS_DW-1:0] cpuRdData,
  // background debug write port
  input  wire logic               bgdWrEn,
  input  wire logic               bgdSel,
  input  wire logic [RSCS_DW-1:0] bgdWrData,
  // external reset causes, held by the reset controller until release
  input  wire logic               porEntry,
  input  wire logic               extPinRstEntry,
  // internal reset sources
  input  wire logic               wdogTimeout,
  input  wire logic               illegalOpcode,
  input  wire logic               stopInstr,
  input  wire logic               bgndInstr,
  input  wire logic               illegalAddr,
  input  wire logic               lowSupply,
  // configuration
  input  wire logic               watchdogEnable,
  input  wire logic               stopPermit,
  input  wire logic               backgroundModePermit,
  input  wire logic               lowVoltageResetEnable,
  // to reset controller and watchdog counter
  output logic                    resetReq,
  output logic                    wdogClear
);

  rscs_wdog_if wd ();

  rscs_wdog_seq u_seq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wd       (wd)
  );

  logic               capPend_q;
  logic               resetReq_q;
  logic               resetReq_d;
  logic               wdogClear_q;
  logic               wdogClear_d;
  logic [RSCS_DW-1:0] rdData_q;
  logic [RSCS_DW-1:0] rdData_d;
  logic [RSCS_DW-1:0] status_q;
  logic [RSCS_DW-1:0] status_d;
  rscs_cause_s        snap_q;
  rscs_cause_s        snap_d;
  rscs_cause_s        srcNow;

  // only status address writes reach the key sequencer
  assign wd.wrStb  = cpuWrEn && (cpuSel == RSCS_SEL_STATUS);
  assign wd.wrData = cpuWrData;

  // live reset sources; the force register has no processor write path
  always_comb begin
    srcNow        = RSCS_CAUSE_NONE;
    srcNow.forced = bgdWrEn && (bgdSel == RSCS_SEL_FORCE)
                    && bgdWrData[RSCS_BIT_FORCE];
    srcNow.wdog   = watchdogEnable
                    && (wdogTimeout || wd.badWrite);
    srcNow.illegal_opcode_flag   = illegalOpcode
                    || (stopInstr && !stopPermit)
                    || (bgndInstr && !backgroundModePermit);
    srcNow.illegal_address_flag   = illegalAddr;
    srcNow.low_voltage_reset    = lowSupply && lowVoltageResetEnable;
  end

  // request reset on the first source and freeze the cause snapshot;
  // the request stays up until rst_n drops it; the snapshot must not
  // reload while rst_n is low or the cause is lost before capture
  always_comb begin
    resetReq_d = resetReq_q;
    snap_d     = snap_q;
    if (!resetReq_q) begin
      if (rst_n) begin
        snap_d = srcNow;
      end
      if (srcNow != RSCS_CAUSE_NONE) begin
        resetReq_d = 1'b1;
      end
    end
  end

  // status is loaded at every edge while rst_n is low, and last at the first edge after reset release
  always_comb begin
    status_d = status_q;
    if (capPend_q) begin
      status_d = RSCS_ALL_CLEAR;
      if (porEntry) begin
        status_d[RSCS_BIT_POR] = 1'b1;
        status_d[RSCS_BIT_LVD] = 1'b1;
      end else if (snap_q.low_voltage_reset) begin
        status_d[RSCS_BIT_POR] = status_q[RSCS_BIT_POR];
        status_d[RSCS_BIT_LVD] = 1'b1;
      end else if (!snap_q.forced) begin
        status_d[RSCS_BIT_PIN]  = extPinRstEntry;
        status_d[RSCS_BIT_WDOG] = snap_q.wdog;
        status_d[RSCS_BIT_ILLEGAL_OPCODE_FLAG] = snap_q.illegal_opcode_flag;
        status_d[RSCS_BIT_ILLEGAL_ADDRESS_FLAG] = snap_q.illegal_address_flag;
      end
    end
  end

  // read data and watchdog restart strobe
  always_comb begin
    rdData_d    = RSCS_READ_ZERO;
    wdogClear_d = wd.serviced;
    if (cpuRdEn && cpuSel == RSCS_SEL_STATUS) begin
      rdData_d = status_q;
    end
    // force register reads fall through to zero
  end

  // control state with reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capPend_q   <= 1'b1;
      resetReq_q  <= 1'b0;
      wdogClear_q <= 1'b0;
      rdData_q    <= RSCS_READ_ZERO;
    end else begin
      capPend_q   <= 1'b0;
      resetReq_q  <= resetReq_d;
      wdogClear_q <= wdogClear_d;
      rdData_q    <= rdData_d;
    end
  end

  // cause state must survive reset, so it carries none; the snapshot
  // stays frozen while rst_n is held low
  always_ff @(posedge core_clk) begin
    status_q <= status_d;
    snap_q   <= snap_d;
  end

  assign cpuRdData = rdData_q;
  assign resetReq  = resetReq_q;
  assign wdogClear = wdogClear_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cap_other;
    capPend_q && !porEntry && !snap_q.low_voltage_reset;
  endsequence

  a_por_flags: assert property (
    capPend_q && porEntry |=> status_q[RSCS_BIT_POR]
      && status_q[RSCS_BIT_LVD] && status_q[RSCS_BIT_PIN:RSCS_BIT_ILLEGAL_ADDRESS_FLAG] == '0)
    else $error("power-on flags wrong");

  a_lvr_keeps_por: assert property (
    capPend_q && !porEntry && snap_q.low_voltage_reset
    |=> status_q[RSCS_BIT_LVD] && !status_q[RSCS_BIT_PIN]
      && status_q[RSCS_BIT_POR] == $past(status_q[RSCS_BIT_POR]))
    else $error("low-voltage flags wrong");

  a_forced_clear: assert property (
    s_cap_other ##0 snap_q.forced |=> status_q == RSCS_ALL_CLEAR)
    else $error("forced reset left a flag set");

  a_other_flags: assert property (
    s_cap_other ##0 !snap_q.forced
    |=> status_q[RSCS_BIT_PIN] == $past(extPinRstEntry)
      && status_q[RSCS_BIT_WDOG] == $past(snap_q.wdog)
      && !status_q[RSCS_BIT_POR] && !status_q[RSCS_BIT_LVD])
    else $error("other reset flags wrong");

  a_bad_key_reset: assert property (
    wd.badWrite && watchdogEnable && !resetReq_q
    |=> resetReq_q && snap_q.wdog ##1 resetReq_q)
    else $error("bad key did not reset");

  a_wdog_gated: assert property (
    $rose(resetReq_q) && snap_q.wdog |-> $past(watchdogEnable))
    else $error("watchdog reset while disabled");

  a_lvr_gated: assert property (
    $rose(resetReq_q) && snap_q.low_voltage_reset |-> $past(lowVoltageResetEnable))
    else $error("low-voltage reset while disabled");

  a_illegal_opcode_flag_gate: assert property (
    stopInstr && !stopPermit && !resetReq_q |=> resetReq_q && snap_q.illegal_opcode_flag)
    else $error("illegal stop not caught");

  a_illegal_address_flag_catch: assert property (
    illegalAddr && !resetReq_q |=> resetReq_q && snap_q.illegal_address_flag)
    else $error("illegal address not caught");

  a_cpu_no_force: assert property (
    $rose(resetReq_q) && snap_q.forced |-> $past(bgdWrEn))
    else $error("forced reset without debug write");

  a_force_req: assert property (
    bgdWrEn && bgdSel == RSCS_SEL_FORCE && bgdWrData[RSCS_BIT_FORCE]
    |=> resetReq_q)
    else $error("debug force did not reset");

  a_force_reads_zero: assert property (
    cpuRdEn && cpuSel == RSCS_SEL_FORCE |=> cpuRdData == RSCS_READ_ZERO)
    else $error("force register read nonzero");

  a_service_keeps: assert property (
    wd.serviced && !capPend_q |=> wdogClear && status_q == $past(status_q))
    else $error("service changed status or missed clear");

  a_reserved_zero: assert property (
    !capPend_q |-> !status_q[RSCS_BIT_RSV2] && !status_q[RSCS_BIT_RSV0])
    else $error("reserved status bit set");

  a_status_read: assert property (
    !capPend_q && cpuRdEn && cpuSel == RSCS_SEL_STATUS
    |=> cpuRdData == $past(status_q))
    else $error("status read mismatch");

endmodule

/* tb/rscs_rst_model.sv */
// reset controller model that answers reset requests of the block
`timescale 1ns/1ns
module rscs_rst_model (
  // clock
  input  wire logic core_clk,
  // reset requests from the block and from the external pin
  input  wire logic resetReq,
  input  wire logic pinPulse,
  // device reset, low while the hold count runs
  output logic      rst_n
);
  logic [3:0] holdCnt_q = 4'h8;

  // any request restarts an 8-cycle reset; the initial count of 8 covers power-up too
  always @(posedge core_clk) begin
    if (resetReq || pinPulse) begin
      holdCnt_q <= 4'h8;
    end else if (holdCnt_q != 4'h0) begin
      holdCnt_q <= holdCnt_q - 4'h1;
    end
  end

  assign rst_n = (holdCnt_q == 4'h0);
endmodule

/* tb/rscs_top_tb_top.sv */
// self-checking bench for the reset cause status block
`timescale 1ns/1ns
module rscs_top_tb_top;
  import rscs_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n, cpuSel, cpuWrEn, cpuRdEn, bgdWrEn, bgdSel, pinPulse;
  logic       porEntry, extPinRstEntry, wdogTimeout, illegalOpcode;
  logic       stopInstr, bgndInstr, illegalAddr, lowSupply, watchdogEnable;
  logic       stopPermit, backgroundModePermit, lowVoltageResetEnable;
  logic       resetReq, wdogClear;
  logic [7:0] cpuWrData, cpuRdData, bgdWrData;
  int         miscompares, cmpCount, cycles, step;
  // hit, debug data, config, select/expect-reset, expected status
  localparam logic [31:0] TBL [18] = '{
    32'h2001_0882, 32'h2001_8C82, 32'h0101_1C20, 32'h0101_0820,
    32'h0201_0C10, 32'h1001_0C08, 32'h0401_2808, 32'h0401_0C10,
    32'h0801_4810, 32'h1001_0C08, 32'h0801_0C10, 32'h2001_8C02,
    32'h8001_0C40, 32'h4001_0040, 32'h40FE_0840, 32'h4001_0C00,
    32'h4201_0C00, 32'h1201_0C18};

  always #25 core_clk = ~core_clk;

  rscs_rst_model rscs_rst_model_i (.core_clk, .resetReq, .pinPulse, .rst_n);

  rscs_top rscs_top_i (.core_clk, .rst_n, .cpuSel, .cpuWrEn, .cpuRdEn,
    .cpuWrData, .cpuRdData, .bgdWrEn, .bgdSel, .bgdWrData, .porEntry,
    .extPinRstEntry, .wdogTimeout, .illegalOpcode, .stopInstr, .bgndInstr,
    .illegalAddr, .lowSupply, .watchdogEnable, .stopPermit,
    .backgroundModePermit, .lowVoltageResetEnable, .resetReq, .wdogClear);

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmpCount++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmpCount++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cpuWr(input logic s, input logic [7:0] d);
    @(posedge core_clk);
    cpuSel <= s;
    cpuWrData <= d;
    cpuWrEn <= 1'b1;
    @(posedge core_clk);
    cpuWrEn <= 1'b0;
  endtask

  // read data stands for one cycle only, so sample right after it lands
  task automatic cpuRd(input logic s, input logic [7:0] e);
    @(posedge core_clk);
    cpuSel <= s;
    cpuRdEn <= 1'b1;
    @(posedge core_clk);
    cpuRdEn <= 1'b0;
    #1 chk8(cpuRdData, e);
  endtask

  // key pair on consecutive cycles, then the one-cycle restart pulse
  task automatic service();
    @(posedge core_clk);
    cpuSel <= RSCS_SEL_STATUS;
    cpuWrData <= RSCS_KEY_ARM;
    cpuWrEn <= 1'b1;
    @(posedge core_clk);
    cpuWrData <= RSCS_KEY_FIRE;
    @(posedge core_clk);
    cpuWrEn <= 1'b0;
    #1 chk1(wdogClear, 1'b1);
    @(posedge core_clk);
    #1 chk1(wdogClear, 1'b0);
  endtask

  // see whether a reset follows, let it finish, then read the status
  task automatic recover(input logic r, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (rst_n === 1'b1 && n < 6);
    chk1(~rst_n, r);
    while (rst_n !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    repeat (2) @(posedge core_clk);
    extPinRstEntry <= 1'b0;
    cpuRd(RSCS_SEL_STATUS, e);
    step++;
    $display("test %0d done", step);
  endtask

  // one table entry: pulse the sources for one cycle under its config
  task automatic trip(input logic [31:0] t);
    @(posedge core_clk);
    {lowSupply, illegalAddr, bgndInstr, stopInstr, illegalOpcode,
     wdogTimeout} <= t[29:24];
    bgdWrEn <= t[30];
    extPinRstEntry <= t[31];
    pinPulse <= t[31];
    bgdWrData <= t[23:16];
    {lowVoltageResetEnable, backgroundModePermit, stopPermit,
     watchdogEnable} <= t[15:12];
    bgdSel <= t[11];
    @(posedge core_clk);
    {lowSupply, illegalAddr, bgndInstr, stopInstr, illegalOpcode,
     wdogTimeout} <= 6'h00;
    bgdWrEn <= 1'b0;
    pinPulse <= 1'b0;
    recover(t[10], t[7:0]);
  endtask

  // cut a hang short well past the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    {cpuSel, cpuWrEn, cpuRdEn, bgdWrEn, bgdSel, pinPulse} = 6'h00;
    {cpuWrData, bgdWrData} = 16'h0000;
    {wdogTimeout, illegalOpcode, stopInstr, bgndInstr} = 4'h0;
    {illegalAddr, lowSupply, extPinRstEntry} = 3'h0;
    {stopPermit, backgroundModePermit, lowVoltageResetEnable} = 3'h0;
    watchdogEnable = 1'b1;
    porEntry = 1'b1;
    @(posedge rst_n);
    repeat (2) @(posedge core_clk);
    porEntry <= 1'b0;
    cpuRd(RSCS_SEL_STATUS, 8'h82);
    cpuRd(RSCS_SEL_FORCE, 8'h00);
    service();
    cpuRd(RSCS_SEL_STATUS, 8'h82);
    cpuWr(RSCS_SEL_FORCE, 8'h01);
    recover(1'b0, 8'h82);
    cpuWr(RSCS_SEL_STATUS, 8'hAA);
    recover(1'b0, 8'h82);
    @(posedge core_clk);
    watchdogEnable <= 1'b0;
    cpuWr(RSCS_SEL_STATUS, 8'h12);
    recover(1'b0, 8'h82);
    foreach (TBL[i]) begin
      trip(TBL[i]);
    end
    @(posedge core_clk);
    watchdogEnable <= 1'b1;
    cpuWr(RSCS_SEL_STATUS, 8'h12);
    recover(1'b1, 8'h20);
    stop_test();
  end
endmodule
